// ### verilog/smtb_pkg.sv
// Behaviour
// - Counter equal to active duty value raises a falling edge event.
// - Counter and duty match sets the duty match flag.
// - Duty value reads and writes as low byte and high byte registers.
// - Duty value moves to active compare at first period event after load request.
// - Duty equal to phase gives falling event with rising event: 0% duty.
// - Duty above period never matches: no falling event, 100% duty.
// - Four time base sources, each with flag and enable: overflow, phase, duty, period.
// - Each flag sets on its event regardless of its enable bit.
// - Summary flag sets on an event or a software-set flag whose own enable bit is set.
// - Flags stay until cleared; module disable clears all but the summary flag.
// - Software-set flag requests interrupt like hardware-set flag when enabled.
// - Two-bit field selects internal fast clock, system clock or external clock pin.
// - Internal fast source keeps clocking the block in sleep, even when disabled.
// - Any mix of four comparators and event pin triggers rising, falling, period, shutdown.
// - Comparator events trigger on rising edge; shutdown follows the level.
// - Event pin enters unsynchronised and triggers events on its rising edge.
// - Period and duty polarity bits invert every enabled input of that event.
package smtb_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLK = 8'h04;
  localparam logic [7:0] ADDR_PER_LO = 8'h08;
  localparam logic [7:0] ADDR_PER_HI = 8'h0c;
  localparam logic [7:0] ADDR_PH_LO = 8'h10;
  localparam logic [7:0] ADDR_PH_HI = 8'h14;
  localparam logic [7:0] ADDR_DC_LO = 8'h18;
  localparam logic [7:0] ADDR_DC_HI = 8'h1c;
  localparam logic [7:0] ADDR_IRQ = 8'h20;
  localparam logic [7:0] ADDR_PERIPH = 8'h24;
  localparam logic [7:0] ADDR_SRC = 8'h28;
  localparam logic [7:0] ADDR_SYNC = 8'h2c;
  localparam logic [7:0] ADDR_CNT_LO = 8'h30;
  localparam logic [7:0] ADDR_CNT_HI = 8'h34;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 7;
  localparam int CTRL_LD = 6;
  localparam int IRQ_FLAG_LSB = 0;
  localparam int IRQ_EN_LSB = 4;
  localparam int PERIPH_FLAG = 0;
  localparam int PERIPH_EN = 1;
  localparam int SYNC_PRPOL = 0;
  localparam int SYNC_DCPOL = 1;
  // Flag index within the four time base sources
  localparam int EV_OVF = 0;
  localparam int EV_PH = 1;
  localparam int EV_DC = 2;
  localparam int EV_PR = 3;
  // Input source select bytes within the source register
  localparam int SRC_RISE_LSB = 0;
  localparam int SRC_FALL_LSB = 8;
  localparam int SRC_PER_LSB = 16;
  localparam int SRC_SHUT_LSB = 24;
  localparam int NUM_IN = 5;
  // ----------------------------------------------------------------
  // Clock source codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CSRC_SYS = 2'h0;
  localparam logic [1:0] CSRC_INT64 = 2'h1;
  localparam logic [1:0] CSRC_EXT = 2'h2;
  localparam logic [15:0] RST_PERIOD = 16'hffff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [31:0] HRESP_OKAY_W = 32'h0000_0000;
endpackage : smtb_pkg

// ### verilog/smtb_edge.sv
`timescale 1ns/1ps
module smtb_edge
  import smtb_pkg::*;
#(
  parameter int WIDTH = 5
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic tick,
  // Inputs and edges
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("smtb_edge width must be positive");
    end
  end

  // Rising edge per input, sampled on module clock ticks
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_edge
      assign rise[gi] = tick & level[gi] & ~prev_r[gi];
      always_comb
      begin
        prev_nxt[gi] = tick ? level[gi] : prev_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_r <= '0;
    end
    else if (ce)
    begin
      prev_r <= prev_nxt;
    end
  end
endmodule : smtb_edge

// ### verilog/smtb_time_base.sv
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module smtb_time_base
  import smtb_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock sources
  input wire logic int64_tick,
  input wire logic ext_clk_pin,
  input wire logic sleep_mode,
  output logic osc_keep_on,
  // Asynchronous inputs
  input wire logic comparator_out_1,
  input wire logic comparator_out_2,
  input wire logic comparator_out_3,
  input wire logic comparator_out_4,
  input wire logic event_input_pin,
  // Events to output stage
  output logic rise_event,
  output logic fall_event,
  output logic period_event,
  output logic shutdown,
  output logic time_base_irq
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic module_enable_r, module_enable_nxt;
  logic buffer_load_request_r, buffer_load_request_nxt;
  logic [1:0] clock_source_select_r, clock_source_select_nxt;
  logic [15:0] period_value_r, period_value_nxt;
  logic [15:0] phase_value_r, phase_value_nxt;
  logic [15:0] duty_compare_value_r, duty_compare_value_nxt;
  logic [15:0] duty_active_r, duty_active_nxt;
  logic [15:0] time_base_counter_r, time_base_counter_nxt;
  logic [3:0] tb_flag_r, tb_flag_nxt;
  logic [3:0] tb_enable_r, tb_enable_nxt;
  logic time_base_summary_flag_r, time_base_summary_flag_nxt;
  logic time_base_summary_enable_r, time_base_summary_enable_nxt;
  logic [31:0] src_sel_r, src_sel_nxt;
  logic period_input_polarity_r, period_input_polarity_nxt;
  logic duty_input_polarity_r, duty_input_polarity_nxt;
  logic ext_prev_r, ext_prev_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [3:0] ev_r, ev_nxt;

  // ----------------------------------------------------------------
  // Module clock tick selection
  // ----------------------------------------------------------------
  logic tick;
  logic ext_tick;
  assign ext_tick = ext_clk_pin & ~ext_prev_r;
  always_comb
  begin
    unique case (clock_source_select_r)
      CSRC_INT64: tick = int64_tick;
      CSRC_EXT: tick = ext_tick;
      default: tick = 1'b1;
    endcase
  end
  // Fast oscillator stays on in sleep whenever selected
  assign osc_keep_on = (clock_source_select_r == CSRC_INT64);

  // ----------------------------------------------------------------
  // Asynchronous inputs
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] in_lvl;
  logic [NUM_IN-1:0] in_inv;
  logic [NUM_IN-1:0] rise_pos;
  logic [NUM_IN-1:0] rise_neg;
  // Pin taken directly, no synchroniser
  assign in_lvl = {event_input_pin, comparator_out_4, comparator_out_3, comparator_out_2,
    comparator_out_1};
  assign in_inv = ~in_lvl;

  smtb_edge #(.WIDTH(NUM_IN)) u_pos (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .tick(tick),
    .level(in_lvl),
    .rise(rise_pos)
  );
  smtb_edge #(.WIDTH(NUM_IN)) u_neg (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .tick(tick),
    .level(in_inv),
    .rise(rise_neg)
  );

  logic async_rise, async_fall, async_per;
  logic [NUM_IN-1:0] sel_rise, sel_fall, sel_per, sel_shut;
  assign sel_rise = src_sel_r[SRC_RISE_LSB +: NUM_IN];
  assign sel_fall = src_sel_r[SRC_FALL_LSB +: NUM_IN];
  assign sel_per = src_sel_r[SRC_PER_LSB +: NUM_IN];
  assign sel_shut = src_sel_r[SRC_SHUT_LSB +: NUM_IN];
  assign async_rise = |(sel_rise & rise_pos);
  assign async_fall = |(sel_fall & (duty_input_polarity_r ? rise_neg : rise_pos));
  assign async_per = |(sel_per & (period_input_polarity_r ? rise_neg : rise_pos));

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  logic run, pr_match, ph_match, dc_match, ovf;
  assign run = module_enable_r & tick;
  assign pr_match = run & (time_base_counter_r == period_value_r);
  assign ph_match = run & (time_base_counter_r == phase_value_r);
  // Never true when duty exceeds period
  assign dc_match = run & (time_base_counter_r == duty_active_r);
  assign ovf = run & ~pr_match & (time_base_counter_r == 16'hffff);

  always_comb
  begin
    time_base_counter_nxt = time_base_counter_r;
    duty_active_nxt = duty_active_r;
    ev_nxt = 4'h0;
    if (!module_enable_r)
    begin
      time_base_counter_nxt = RST_ZERO;
    end
    else if (run)
    begin
      time_base_counter_nxt = pr_match ? RST_ZERO : 16'(time_base_counter_r + 16'h0001);
    end
    if (pr_match && buffer_load_request_r)
    begin
      duty_active_nxt = duty_compare_value_r;
    end
    // Duty equal to phase fires with the rising edge event
    ev_nxt[0] = ph_match | (module_enable_r & async_rise);
    ev_nxt[1] = dc_match | (module_enable_r & async_fall);
    ev_nxt[2] = pr_match | (module_enable_r & async_per);
    ev_nxt[3] = module_enable_r & |(sel_shut & in_lvl);
  end
  assign rise_event = ev_r[0];
  assign fall_event = ev_r[1];
  assign period_event = ev_r[2];
  assign shutdown = ev_r[3];

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic take;
  logic [3:0] hw_ev;
  logic [7:0] wd;
  assign take = hsel & hready & htrans[1];
  assign wd = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY_W[0];
  assign hrdata = hrdata_r;
  assign hw_ev = {pr_match, dc_match, ph_match, ovf};
  assign time_base_irq = time_base_summary_flag_r & time_base_summary_enable_r;

  always_comb
  begin
    module_enable_nxt = module_enable_r;
    buffer_load_request_nxt = buffer_load_request_r;
    clock_source_select_nxt = clock_source_select_r;
    period_value_nxt = period_value_r;
    phase_value_nxt = phase_value_r;
    duty_compare_value_nxt = duty_compare_value_r;
    tb_flag_nxt = tb_flag_r;
    tb_enable_nxt = tb_enable_r;
    time_base_summary_flag_nxt = time_base_summary_flag_r;
    time_base_summary_enable_nxt = time_base_summary_enable_r;
    src_sel_nxt = src_sel_r;
    period_input_polarity_nxt = period_input_polarity_r;
    duty_input_polarity_nxt = duty_input_polarity_r;
    ext_prev_nxt = ext_clk_pin;
    wr_pend_nxt = take & hwrite;
    wr_addr_nxt = take ? haddr : wr_addr_r;
    hrdata_nxt = hrdata_r;
    if (pr_match)
    begin
      buffer_load_request_nxt = 1'b0;
    end
    if (wr_pend_r)
    begin
      unique case (wr_addr_r)
        ADDR_CTRL:
        begin
          module_enable_nxt = wd[CTRL_EN];
          buffer_load_request_nxt = wd[CTRL_LD] | buffer_load_request_nxt;
        end
        ADDR_CLK: clock_source_select_nxt = wd[1:0];
        ADDR_PER_LO: period_value_nxt[7:0] = wd;
        ADDR_PER_HI: period_value_nxt[15:8] = wd;
        ADDR_PH_LO: phase_value_nxt[7:0] = wd;
        ADDR_PH_HI: phase_value_nxt[15:8] = wd;
        ADDR_DC_LO: duty_compare_value_nxt[7:0] = wd;
        ADDR_DC_HI: duty_compare_value_nxt[15:8] = wd;
        ADDR_IRQ:
        begin
          tb_flag_nxt = wd[IRQ_FLAG_LSB +: 4];
          tb_enable_nxt = wd[IRQ_EN_LSB +: 4];
        end
        ADDR_PERIPH:
        begin
          time_base_summary_flag_nxt = wd[PERIPH_FLAG];
          time_base_summary_enable_nxt = wd[PERIPH_EN];
        end
        ADDR_SRC: src_sel_nxt = hwdata;
        ADDR_SYNC:
        begin
          period_input_polarity_nxt = wd[SYNC_PRPOL];
          duty_input_polarity_nxt = wd[SYNC_DCPOL];
        end
        default: ;
      endcase
    end
    // Disable wipes the four flags but keeps the summary flag
    if (module_enable_r && !module_enable_nxt)
    begin
      tb_flag_nxt = 4'h0;
    end
    // Hardware set wins over a simultaneous software clear
    tb_flag_nxt = tb_flag_nxt | hw_ev;
    // Software-set flags also request when enabled
    if (|(tb_flag_nxt & tb_enable_nxt & ~tb_flag_r) || |(hw_ev & tb_enable_r))
    begin
      time_base_summary_flag_nxt = 1'b1;
    end
    if (take && !hwrite)
    begin
      unique case (haddr)
        ADDR_CTRL: hrdata_nxt = {24'h00_0000, module_enable_r, buffer_load_request_r, 6'h00};
        ADDR_CLK: hrdata_nxt = {30'h0000_0000, clock_source_select_r};
        ADDR_PER_LO: hrdata_nxt = {24'h00_0000, period_value_r[7:0]};
        ADDR_PER_HI: hrdata_nxt = {24'h00_0000, period_value_r[15:8]};
        ADDR_PH_LO: hrdata_nxt = {24'h00_0000, phase_value_r[7:0]};
        ADDR_PH_HI: hrdata_nxt = {24'h00_0000, phase_value_r[15:8]};
        ADDR_DC_LO: hrdata_nxt = {24'h00_0000, duty_compare_value_r[7:0]};
        ADDR_DC_HI: hrdata_nxt = {24'h00_0000, duty_compare_value_r[15:8]};
        ADDR_IRQ: hrdata_nxt = {24'h00_0000, tb_enable_r, tb_flag_r};
        ADDR_PERIPH: hrdata_nxt = {30'h0000_0000, time_base_summary_enable_r, time_base_summary_flag_r};
        ADDR_SRC: hrdata_nxt = src_sel_r;
        ADDR_SYNC: hrdata_nxt = {30'h0000_0000, duty_input_polarity_r, period_input_polarity_r};
        ADDR_CNT_LO: hrdata_nxt = {24'h00_0000, time_base_counter_r[7:0]};
        ADDR_CNT_HI: hrdata_nxt = {24'h00_0000, time_base_counter_r[15:8]};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      module_enable_r <= 1'b0;
      buffer_load_request_r <= 1'b0;
      clock_source_select_r <= CSRC_SYS;
      period_value_r <= RST_PERIOD;
      phase_value_r <= RST_ZERO;
      duty_compare_value_r <= RST_ZERO;
      duty_active_r <= RST_ZERO;
      time_base_counter_r <= RST_ZERO;
      tb_flag_r <= 4'h0;
      tb_enable_r <= 4'h0;
      time_base_summary_flag_r <= 1'b0;
      time_base_summary_enable_r <= 1'b0;
      src_sel_r <= 32'h0000_0000;
      period_input_polarity_r <= 1'b0;
      duty_input_polarity_r <= 1'b0;
      ext_prev_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      ev_r <= 4'h0;
    end
    else if (ce)
    begin
      module_enable_r <= module_enable_nxt;
      buffer_load_request_r <= buffer_load_request_nxt;
      clock_source_select_r <= clock_source_select_nxt;
      period_value_r <= period_value_nxt;
      phase_value_r <= phase_value_nxt;
      duty_compare_value_r <= duty_compare_value_nxt;
      duty_active_r <= duty_active_nxt;
      time_base_counter_r <= time_base_counter_nxt;
      tb_flag_r <= tb_flag_nxt;
      tb_enable_r <= tb_enable_nxt;
      time_base_summary_flag_r <= time_base_summary_flag_nxt;
      time_base_summary_enable_r <= time_base_summary_enable_nxt;
      src_sel_r <= src_sel_nxt;
      period_input_polarity_r <= period_input_polarity_nxt;
      duty_input_polarity_r <= duty_input_polarity_nxt;
      ext_prev_r <= ext_prev_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      ev_r <= ev_nxt;
    end
  end
endmodule : smtb_time_base

// ### bench/smtb_far_src.sv
`timescale 1ns/1ps
module smtb_far_src
  import smtb_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Wanted levels, bit 4 is the pin
  input wire logic [4:0] pat,
  // Event sources
  output logic comparator_out_1,
  output logic comparator_out_2,
  output logic comparator_out_3,
  output logic comparator_out_4,
  output logic event_input_pin
);
  logic [3:0] cmp_r;
  // Comparators reach the block already synchronised
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cmp_r <= 4'h0;
    else
      cmp_r <= pat[3:0];
  assign {comparator_out_4, comparator_out_3, comparator_out_2, comparator_out_1} = cmp_r;
  // Pin passes straight through
  assign event_input_pin = pat[4];
endmodule : smtb_far_src

// ### bench/smtb_time_base_props.sv
`timescale 1ns/1ps
module smtb_props
  import smtb_pkg::*;
(
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Sources and events
  input wire logic osc_keep_on,
  input wire logic comparator_out_1,
  input wire logic event_input_pin,
  input wire logic rise_event,
  input wire logic fall_event,
  input wire logic period_event,
  input wire logic shutdown,
  input wire logic time_base_irq
);
  // ----------------------------------------
  // Register shadows
  // ----------------------------------------
  typedef struct packed {logic wp; logic [7:0] wa, ctl, ck, pe; logic [31:0] src;} smtb_shadow_s;
  smtb_shadow_s sh_r, sh_nxt;
  always_comb
  begin
    sh_nxt = sh_r;
    if (ce)
    begin
      sh_nxt.wp = hsel && hready && htrans[1] && hwrite;
      sh_nxt.wa = haddr;
      if (sh_r.wp && sh_r.wa == ADDR_CTRL) sh_nxt.ctl = hwdata[7:0];
      if (sh_r.wp && sh_r.wa == ADDR_CLK) sh_nxt.ck = hwdata[7:0];
      if (sh_r.wp && sh_r.wa == ADDR_PERIPH) sh_nxt.pe = hwdata[7:0];
      if (sh_r.wp && sh_r.wa == ADDR_SRC) sh_nxt.src = hwdata;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      sh_r <= '0;
    else
      sh_r <= sh_nxt;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  quiet_start_a: assert property ($rose(hresetn) |-> !rise_event && !fall_event && !period_event && !time_base_irq)
    else $error("output active out of reset");
  ce_freeze_a: assert property (!ce |=> $stable(hrdata) && $stable(rise_event) && $stable(period_event))
    else $error("state moved with clock enable low");
  osc_keep_a: assert property (osc_keep_on == (sh_r.ck[1:0] == CSRC_INT64))
    else $error("fast oscillator request wrong");
  irq_gate_a: assert property (time_base_irq |-> sh_r.pe[PERIPH_EN])
    else $error("request without summary enable");
  idle_quiet_a: assert property (!sh_r.ctl[CTRL_EN] && !$past(sh_r.ctl[CTRL_EN]) |->
    !rise_event && !fall_event && !period_event)
    else $error("event while disabled");
  pin_rise_a: assert property (ce && sh_r.ctl[CTRL_EN] && sh_r.ck[1:0] == CSRC_SYS && sh_r.src[SRC_RISE_LSB+4]
    && $rose(event_input_pin) |-> ##[1:3] rise_event)
    else $error("pin edge gave no rising event");
  shut_level_a: assert property ((ce && sh_r.ctl[CTRL_EN] && sh_r.ck[1:0] == CSRC_SYS && sh_r.src[SRC_SHUT_LSB]
    && comparator_out_1) [*3] |-> shutdown)
    else $error("shutdown does not follow level");
endmodule : smtb_props
bind smtb_time_base smtb_props u_props (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .osc_keep_on(osc_keep_on), .comparator_out_1(comparator_out_1), .event_input_pin(event_input_pin),
  .rise_event(rise_event), .fall_event(fall_event), .period_event(period_event), .shutdown(shutdown),
  .time_base_irq(time_base_irq));

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import smtb_pkg::*;
;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, int64_tick, ext_clk_pin, sleep_mode;
  logic osc_keep_on, rise_event, fall_event, period_event, shutdown, time_base_irq;
  logic comparator_out_1, comparator_out_2, comparator_out_3, comparator_out_4, event_input_pin;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q0, q1;
  logic [4:0] pat;
  int num_errors = 0;
  int cmp_count = 0;
  typedef struct packed {logic [7:0] a; logic [31:0] d, e;} smtb_row_s;
  typedef struct packed {logic [1:0] s; logic [4:0] p; logic [31:0] e;} smtb_arow_s;
  smtb_row_s rows [16] = '{'{ADDR_PER_LO, 32'hffff_ff09, 32'h0000_0009}, '{ADDR_PER_HI, 32'h0, 32'h0},
    '{ADDR_PH_LO, 32'h2, 32'h2}, '{ADDR_PH_HI, 32'h0, 32'h0}, '{ADDR_DC_LO, 32'h5, 32'h5},
    '{ADDR_DC_HI, 32'h0, 32'h0}, '{ADDR_CLK, 32'h1, 32'h1}, '{ADDR_CLK, 32'h0, 32'h0},
    '{ADDR_SRC, 32'hffff_ffff, 32'hffff_ffff}, '{ADDR_SRC, 32'h0, 32'h0}, '{ADDR_SYNC, 32'hff, 32'h3},
    '{ADDR_SYNC, 32'h0, 32'h0}, '{ADDR_IRQ, 32'hf0, 32'hf0}, '{ADDR_IRQ, 32'h0, 32'h0},
    '{8'h3c, 32'hffff_ffff, 32'h0}, '{ADDR_CNT_LO, 32'h55, 32'h0}};
  // Counts of rise, fall, period events, then shutdown level
  smtb_arow_s arows [7] = '{'{2'h1, 5'h10, 32'h0100_0000}, '{2'h1, 5'h00, 32'h0000_0100},
    '{2'h1, 5'h02, 32'h0001_0000}, '{2'h1, 5'h03, 32'h0000_0001}, '{2'h2, 5'h00, 32'h0001_0000},
    '{2'h2, 5'h02, 32'h0000_0000}, '{2'h2, 5'h00, 32'h0001_0000}};
  logic [7:0] radr [8] = '{ADDR_PER_LO, ADDR_PER_HI, ADDR_CTRL, ADDR_CLK, ADDR_DC_LO, ADDR_IRQ, ADDR_PERIPH, ADDR_SRC};
  assign hready = hreadyout;
  smtb_time_base dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .int64_tick(int64_tick), .ext_clk_pin(ext_clk_pin), .sleep_mode(sleep_mode),
    .osc_keep_on(osc_keep_on), .comparator_out_1(comparator_out_1), .comparator_out_2(comparator_out_2),
    .comparator_out_3(comparator_out_3), .comparator_out_4(comparator_out_4), .event_input_pin(event_input_pin),
    .rise_event(rise_event), .fall_event(fall_event), .period_event(period_event), .shutdown(shutdown),
    .time_base_irq(time_base_irq));
  smtb_far_src far (.hclk(hclk), .hresetn(hresetn), .pat(pat), .comparator_out_1(comparator_out_1),
    .comparator_out_2(comparator_out_2), .comparator_out_3(comparator_out_3),
    .comparator_out_4(comparator_out_4), .event_input_pin(event_input_pin));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    $display("errors %0d of %0d compares", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge hclk);
    end
    if (n == 20)
    begin
      num_errors++;
      final_report();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  // Rise and fall offsets after a period event, 0 when absent
  task automatic frame(input int r, input int f);
    int i, rr, ff, pp;
    rr = 0;
    ff = 0;
    pp = 0;
    for (i = 0; i < 40 && period_event !== 1'b1; i++) @(posedge hclk);
    for (i = 1; i < 40 && pp == 0; i++)
    begin
      @(posedge hclk);
      if (rise_event && rr == 0) rr = i;
      if (fall_event && ff == 0) ff = i;
      if (period_event) pp = i;
    end
    chk(rr, r);
    chk(ff, f);
    chk(pp, 10);
  endtask : frame
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial
  begin
    repeat (100000) @(posedge hclk);
    num_errors++;
    final_report();
  end
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, ext_clk_pin, sleep_mode, pat} = '0;
    {ce, int64_tick} = 2'b11;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q0);
      chk(q0, rows[i].e);
    end
    wr(ADDR_CTRL, 32'h0000_00c0);
    frame(3, 6);
    wr(ADDR_DC_LO, 32'h0000_0008);
    frame(3, 6);
    wr(ADDR_CTRL, 32'h0000_00c0);
    frame(3, 9);
    wr(ADDR_DC_LO, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_00c0);
    frame(3, 3);
    wr(ADDR_DC_LO, 32'h0000_000c);
    wr(ADDR_CTRL, 32'h0000_00c0);
    frame(3, 0);
    rd(ADDR_IRQ, q0);
    chk(q0, 32'h0000_000e);
    rd(ADDR_PERIPH, q0);
    chk(q0, 32'h0);
    wr(ADDR_PERIPH, 32'h0000_0002);
    wr(ADDR_IRQ, 32'h0000_0080);
    frame(3, 0);
    rd(ADDR_PERIPH, q0);
    chk(q0, 32'h0000_0003);
    chk(time_base_irq, 1'b1);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_IRQ, q0);
    chk(q0, 32'h0000_0080);
    rd(ADDR_PERIPH, q0);
    chk(q0, 32'h0000_0003);
    wr(ADDR_PERIPH, 32'h0000_0002);
    rd(ADDR_PERIPH, q0);
    chk(time_base_irq, 1'b0);
    wr(ADDR_IRQ, 32'h0000_0088);
    rd(ADDR_PERIPH, q0);
    chk(q0, 32'h0000_0003);
    chk(time_base_irq, 1'b1);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk({rise_event, fall_event, period_event, shutdown, time_base_irq}, 5'h0);
    foreach (radr[i])
    begin
      rd(radr[i], q0);
      chk(q0, i < 2 ? 32'h0000_00ff : 32'h0);
    end
    wr(ADDR_SRC, 32'h0110_0210);
    wr(ADDR_SYNC, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0080);
    ce <= 1'b0;
    repeat (4) @(posedge hclk);
    ce <= 1'b1;
    foreach (arows[i])
    begin
      int cr, cf, cp;
      wr(ADDR_SYNC, {30'h0, arows[i].s});
      pat <= arows[i].p;
      {cr, cf, cp} = '0;
      repeat (6)
      begin
        @(posedge hclk);
        cr += rise_event;
        cf += fall_event;
        cp += period_event;
      end
      chk({cr[7:0], cf[7:0], cp[7:0], 7'h0, shutdown}, arows[i].e);
    end
    wr(ADDR_CLK, {30'h0, CSRC_EXT});
    rd(ADDR_CNT_LO, q0);
    repeat (3)
    begin
      ext_clk_pin <= 1'b1;
      repeat (2) @(posedge hclk);
      ext_clk_pin <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    rd(ADDR_CNT_LO, q1);
    chk(q1[7:0] - q0[7:0], 32'h3);
    int64_tick <= 1'b0;
    wr(ADDR_CLK, {30'h0, CSRC_INT64});
    rd(ADDR_CNT_LO, q0);
    repeat (5) @(posedge hclk);
    rd(ADDR_CNT_LO, q1);
    chk(q1, q0);
    int64_tick <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(ADDR_CNT_LO, q0);
    chk(q0[7:0] - q1[7:0], 32'h4);
    sleep_mode <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_CTRL, q1);
    chk(osc_keep_on, 1'b1);
    wr(ADDR_CLK, {30'h0, CSRC_SYS});
    @(posedge hclk);
    chk(osc_keep_on, 1'b0);
    final_report();
  end
endmodule : tb_top
